// ---- include/tsc_pkg.sv ----
package tsc_pkg;

    // core clock and documented times, in their own units
    localparam int unsigned CORE_CLK_KHZ = 100_000;
    localparam int unsigned UPDATE_MS = 80;
    localparam int unsigned ONESHOT_US = 48_500;
    localparam int unsigned TIMEOUT_MS = 25;

    // pointer values selecting each register
    localparam logic [2:0] PTR_RESULT = 3'h0;
    localparam logic [2:0] PTR_CONFIG = 3'h1;
    localparam logic [2:0] PTR_HYST = 3'h2;
    localparam logic [2:0] PTR_OVERTEMP = 3'h3;
    localparam logic [2:0] PTR_ONESHOT = 3'h4;

    // configuration field positions
    localparam int CFG_SHUTDOWN = 0;
    localparam int CFG_INT_MODE = 1;
    localparam int CFG_POLARITY = 2;
    localparam int CFG_QUEUE_LO = 3;
    localparam int CFG_QUEUE_HI = 4;
    localparam int CFG_ONESHOT = 5;
    localparam int CFG_ROLE = 7;

    // reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [15:0] HYST_RST = 16'h4B00;
    localparam logic [15:0] OVERTEMP_RST = 16'h5000;
    localparam logic [7:0] POINTER_RST = 8'h00;

    // bus address: fixed upper nibble, low bit set by the device variant
    localparam logic [3:0] ADDR_FIXED = 4'h9;

    // fault counts selected by the queue field
    localparam logic [2:0] FAULTS_Q0 = 3'h1;
    localparam logic [2:0] FAULTS_Q1 = 3'h2;
    localparam logic [2:0] FAULTS_Q2 = 3'h4;
    localparam logic [2:0] FAULTS_Q3 = 3'h6;

    typedef enum logic [1:0] {EV_START_W, EV_START_R, EV_WBYTE, EV_RBYTE} tsc_ev_kind_t;

    // event handed from the link domain to the core domain
    typedef struct packed {
        tsc_ev_kind_t kind;
        logic [7:0] data;
    } tsc_ev_t;

endpackage

// ---- rtl/tsc_temp_sensor.sv ----
`timescale 1ns/1ns
// Summary of operation
// - normal mode converts every 80 ms, stores result, compares with overtemperature limit.
// - reads return the stored value and never disturb a running conversion.
// - one-shot write while shut down runs one conversion then shuts down again.
// - config bit 5 enters one-shot mode; one-shot data is discarded.
// - comparator output clears alone once result falls below hysteresis.
// - interrupt output clears only after a register read and result below hysteresis.
// - config bit 1 chooses comparator (0) or interrupt (1) behaviour; the code forces interrupt behaviour whenever bit 7 is set.
// - config bit 2 chooses active low (0) or active high (1) output.
// - config bit 7 chooses overtemperature output (0) or bus alert role (1).
// - result and limits are 12-bit two's complement, left aligned, low nibble zero.
// - sixteen-bit registers move upper byte first; master may stop after one.
// - config bits 4:3 need one, two, four or six faults.
// - the fault count must be met by consecutive faulting conversions.
// - write-only pointer selects the target by three low bits, resets to zero.
// - pointer 0 result, 1 config, 2 hysteresis, 3 overtemperature, 4 one-shot.
// - result is read only; other registers accept writes.
// - hysteresis resets to 0x4B00, overtemperature limit to 0x5000.
// - bus address is 1001 followed by a zero, the address-select pin bit and the variant bit.
// - comparator output sets at or above limit, clears below hysteresis.
// - interrupt output cleared by a read re-arms only on a new limit crossing.
// - a 25 ms silence on the data line abandons the bus transaction.
module tsc_temp_sensor
#(
    parameter int unsigned UPDATE_CYCLES = tsc_pkg::UPDATE_MS * (tsc_pkg::CORE_CLK_KHZ),
    parameter int unsigned ONESHOT_CYCLES = tsc_pkg::ONESHOT_US * (tsc_pkg::CORE_CLK_KHZ / 1000),
    parameter int unsigned TIMEOUT_CYCLES = tsc_pkg::TIMEOUT_MS * (tsc_pkg::CORE_CLK_KHZ),
    parameter bit ADDR_VARIANT = 1'b0
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic address_select_pin_i,
    input wire logic [11:0] temp_sample_i,
    output logic adc_power_o,
    output logic alert_output_o,
    output logic alert_output_oe_o
);
    import tsc_pkg::*;

    // ---------------- link domain: bus slave on the oversampling clock ----------------
    typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_WRITE, LK_ACK, LK_READ, LK_RACK, LK_WAIT} tsc_lk_state_t;

    tsc_lk_state_t lk_state_q;
    logic [2:0] scl_s_q, sda_s_q, ce_lk_q, abort_lk_q;
    logic [1:0] pin_s_q;
    logic [1:0] ack_lk_q;
    logic ack_seen_q;
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic rw_q;
    logic req_tgl_q;
    tsc_ev_t ev_q;
    logic [7:0] rbyte_q;
    logic [7:0] rdata_q;
    logic ack_tgl_q;
    logic [7:0] rdata_lk_q;
    logic timeout_q;

    // pins pass two flops; third stage only feeds the edge detectors
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
            pin_s_q <= 2'h0;
            ce_lk_q <= 3'h0;
            abort_lk_q <= 3'h0;
            ack_lk_q <= 2'h0;
            ack_seen_q <= 1'b0;
        end
        else
        begin
            scl_s_q <= {scl_s_q[1:0], scl_i};
            sda_s_q <= {sda_s_q[1:0], sda_i};
            pin_s_q <= {pin_s_q[0], address_select_pin_i};
            ce_lk_q <= {ce_lk_q[1:0], ce_i};
            abort_lk_q <= {abort_lk_q[1:0], timeout_q};
            ack_lk_q <= {ack_lk_q[0], ack_tgl_q};
            ack_seen_q <= ack_lk_q[1];
        end
    end

    wire lk_en = ce_lk_q[1];
    wire scl_rise = scl_s_q[1] & ~scl_s_q[2];
    wire scl_fall = ~scl_s_q[1] & scl_s_q[2];
    wire bus_start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
    wire bus_stop = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
    wire abort_rise = abort_lk_q[1] & ~abort_lk_q[2];
    wire ack_arrive = ack_lk_q[1] ^ ack_seen_q;
    wire [6:0] own_addr = {ADDR_FIXED, 1'b0, pin_s_q[1], ADDR_VARIANT};
    wire addr_hit = (shift_q[7:1] == own_addr);

    // byte engine: sample on rising clock, change the data line on falling clock
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            lk_state_q <= LK_IDLE;
            shift_q <= 8'h00;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
            req_tgl_q <= 1'b0;
            ev_q <= '0;
            rbyte_q <= 8'h00;
        end
        else if (lk_en)
        begin
            if (abort_rise && lk_state_q != LK_IDLE)
                lk_state_q <= LK_IDLE;
            else if (bus_start)
            begin
                lk_state_q <= LK_ADDR;
                cnt_q <= 4'h0;
            end
            else if (bus_stop)
                lk_state_q <= LK_IDLE;
            else if (scl_rise && (lk_state_q == LK_ADDR || lk_state_q == LK_WRITE))
            begin
                shift_q <= {shift_q[6:0], sda_s_q[1]};
                cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_rise && lk_state_q == LK_RACK)
            begin
                if (sda_s_q[1])
                    lk_state_q <= LK_WAIT; // master ended the read
                else
                begin
                    ev_q <= '{kind: EV_RBYTE, data: 8'h00};
                    req_tgl_q <= ~req_tgl_q;
                end
            end
            else if (scl_fall)
            begin
                case (lk_state_q)
                    LK_ADDR:
                        if (cnt_q == 4'h8)
                        begin
                            if (addr_hit)
                            begin
                                lk_state_q <= LK_ACK;
                                rw_q <= shift_q[0];
                                ev_q <= '{kind: (shift_q[0] ? EV_START_R : EV_START_W), data: 8'h00};
                                req_tgl_q <= ~req_tgl_q;
                            end
                            else
                                lk_state_q <= LK_WAIT;
                        end
                    LK_WRITE:
                        if (cnt_q == 4'h8)
                        begin
                            lk_state_q <= LK_ACK;
                            ev_q <= '{kind: EV_WBYTE, data: shift_q};
                            req_tgl_q <= ~req_tgl_q;
                        end
                    LK_ACK, LK_RACK:
                    begin
                        cnt_q <= 4'h0;
                        if (rw_q)
                        begin
                            lk_state_q <= LK_READ;
                            rbyte_q <= rdata_lk_q;
                        end
                        else
                            lk_state_q <= LK_WRITE;
                    end
                    LK_READ:
                        if (cnt_q == 4'h7)
                            lk_state_q <= LK_RACK;
                        else
                        begin
                            rbyte_q <= {rbyte_q[6:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    default:
                        lk_state_q <= lk_state_q;
                endcase
            end
        end
    end

    // read byte captured once the core answer has crossed; core holds it stable
    always_ff @(posedge link_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_lk_q <= 8'h00;
        else if (ack_arrive)
            rdata_lk_q <= rdata_q;
    end

    // open drain: only ever pull low
    assign sda_o = 1'b0;
    assign sda_oe_o = (lk_state_q == LK_ACK) | ((lk_state_q == LK_READ) & ~rbyte_q[7]);

    // ---------------- core domain: registers, conversions, alert ----------------
    typedef enum logic [1:0] {CV_IDLE, CV_NORMAL, CV_ONESHOT} tsc_cv_state_t;

    logic [2:0] req_c_q;
    logic [1:0] sda_c_q;
    logic sda_c_prev_q;
    logic [31:0] quiet_q;
    logic [7:0] pointer_q;
    logic [7:0] config_q;
    logic [15:0] temp_result_q;
    logic [15:0] hyst_q;
    logic [15:0] overtemp_q;
    logic [7:0] hold_hi_q;
    logic [1:0] idx_q;
    tsc_cv_state_t cv_state_q;
    logic [31:0] cv_cnt_q;
    logic [2:0] fault_cnt_q;
    logic alert_q;
    logic rd_seen_q;
    logic below_seen_q;

    // request toggle crossing and data-line watch for the silence timer
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            req_c_q <= 3'h0;
            sda_c_q <= 2'h3;
            sda_c_prev_q <= 1'b1;
        end
        else
        begin
            req_c_q <= {req_c_q[1:0], req_tgl_q};
            sda_c_q <= {sda_c_q[0], sda_i};
            sda_c_prev_q <= sda_c_q[1];
        end
    end

    wire ev_new = ce_i & (req_c_q[1] ^ req_c_q[2]);
    wire ev_start = ev_new & (ev_q.kind == EV_START_W || ev_q.kind == EV_START_R);
    wire ev_read = ev_new & (ev_q.kind == EV_START_R || ev_q.kind == EV_RBYTE);
    wire ev_write = ev_new & (ev_q.kind == EV_WBYTE);
    wire [2:0] sel = pointer_q[2:0];
    wire ptr_write = ev_write & (idx_q == 2'h0);
    wire data_write = ev_write & (idx_q != 2'h0);
    wire cfg_write = data_write & (sel == PTR_CONFIG) & (idx_q == 2'h1);
    wire lim_commit = data_write & (idx_q == 2'h2) & (sel == PTR_HYST || sel == PTR_OVERTEMP);
    wire oneshot_hit = data_write & (sel == PTR_ONESHOT) & (idx_q == 2'h1);
    wire [1:0] rd_idx = (ev_q.kind == EV_START_R) ? 2'h0 : idx_q;

    // pick the byte a read returns: upper byte first, then lower byte
    function automatic logic [7:0] rd_byte(input logic [15:0] word, input logic second);
        rd_byte = second ? word[7:0] : word[15:8];
    endfunction

    wire [15:0] sel_word = (sel == PTR_RESULT) ? temp_result_q :
                           (sel == PTR_HYST) ? hyst_q :
                           (sel == PTR_OVERTEMP) ? overtemp_q : {config_q, config_q};
    wire [7:0] rd_next = rd_byte(sel_word, rd_idx[0]);

    // data-line silence timer; a level crosses to the link where its rise aborts
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            quiet_q <= 32'h0000_0000;
            timeout_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (sda_c_q[1] != sda_c_prev_q)
                quiet_q <= 32'h0000_0000;
            else if (quiet_q != TIMEOUT_CYCLES)
                quiet_q <= quiet_q + 32'h0000_0001;
            timeout_q <= (quiet_q == TIMEOUT_CYCLES);
        end
    end

    // register file; result is never written from the bus, reserved bit 6 is stored inertly
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pointer_q <= POINTER_RST;
            config_q <= CONFIG_RST;
            hyst_q <= HYST_RST;
            overtemp_q <= OVERTEMP_RST;
            hold_hi_q <= 8'h00;
            idx_q <= 2'h0;
            rdata_q <= 8'h00;
            ack_tgl_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (ev_new)
                ack_tgl_q <= ~ack_tgl_q;
            if (ev_start)
                idx_q <= (ev_q.kind == EV_START_R) ? 2'h1 : 2'h0;
            else if (ev_new && idx_q != 2'h3)
                idx_q <= idx_q + 2'h1;
            if (ev_read)
                rdata_q <= rd_next;
            if (ptr_write)
                pointer_q <= ev_q.data;
            if (cfg_write)
                config_q <= ev_q.data;
            if (data_write && idx_q == 2'h1)
                hold_hi_q <= ev_q.data;
            if (lim_commit && sel == PTR_HYST)
                hyst_q <= {hold_hi_q, ev_q.data[7:4], 4'h0};
            if (lim_commit && sel == PTR_OVERTEMP)
                overtemp_q <= {hold_hi_q, ev_q.data[7:4], 4'h0};
        end
    end

    wire cfg_off = config_q[CFG_SHUTDOWN] | config_q[CFG_ONESHOT];
    wire load_en = ce_i & (cv_state_q != CV_IDLE) &
                   (cv_cnt_q == ((cv_state_q == CV_NORMAL) ? UPDATE_CYCLES : ONESHOT_CYCLES) - 1);

    // conversion scheduler: free-running period in normal mode, single shot otherwise
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cv_state_q <= CV_IDLE;
            cv_cnt_q <= 32'h0000_0000;
            temp_result_q <= RESULT_RST;
        end
        else if (ce_i)
        begin
            if (load_en)
                temp_result_q <= {temp_sample_i, 4'h0};
            case (cv_state_q)
                CV_IDLE:
                begin
                    cv_cnt_q <= 32'h0000_0000;
                    if (!cfg_off)
                        cv_state_q <= CV_NORMAL;
                    else if (oneshot_hit)
                        cv_state_q <= CV_ONESHOT;
                end
                CV_NORMAL:
                    if (cfg_off)
                        cv_state_q <= CV_IDLE;
                    else
                        cv_cnt_q <= load_en ? 32'h0000_0000 : cv_cnt_q + 32'h0000_0001;
                CV_ONESHOT:
                    if (load_en)
                        cv_state_q <= CV_IDLE;
                    else
                        cv_cnt_q <= cv_cnt_q + 32'h0000_0001;
                default:
                    cv_state_q <= CV_IDLE;
            endcase
        end
    end

    // comparison against the limits at each fresh result
    wire [15:0] new_result = {temp_sample_i, 4'h0};
    wire is_fault = $signed(new_result) >= $signed(overtemp_q);
    wire is_below = $signed(new_result) < $signed(hyst_q);
    wire int_mode = config_q[CFG_INT_MODE] | config_q[CFG_ROLE];
    wire [2:0] need = (config_q[CFG_QUEUE_HI:CFG_QUEUE_LO] == 2'h0) ? FAULTS_Q0 :
                      (config_q[CFG_QUEUE_HI:CFG_QUEUE_LO] == 2'h1) ? FAULTS_Q1 :
                      (config_q[CFG_QUEUE_HI:CFG_QUEUE_LO] == 2'h2) ? FAULTS_Q2 : FAULTS_Q3;
    wire [2:0] fault_next = is_fault ? ((fault_cnt_q == need) ? need : fault_cnt_q + 3'h1) : 3'h0;
    wire trip = load_en & is_fault & (fault_next == need);
    wire int_clear = rd_seen_q & below_seen_q;

    // alert state; in interrupt behaviour a new trip beats a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fault_cnt_q <= 3'h0;
            alert_q <= 1'b0;
            rd_seen_q <= 1'b0;
            below_seen_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (load_en)
                fault_cnt_q <= fault_next;
            if (!int_mode)
            begin
                rd_seen_q <= 1'b0;
                below_seen_q <= 1'b0;
                if (trip)
                    alert_q <= 1'b1;
                else if (load_en && is_below)
                    alert_q <= 1'b0;
            end
            else if (trip && !alert_q && !rd_seen_q)
            begin
                alert_q <= 1'b1;
                below_seen_q <= 1'b0;
            end
            else
            begin
                if (ev_read && alert_q)
                    rd_seen_q <= 1'b1;
                if (load_en && is_below && alert_q)
                    below_seen_q <= 1'b1;
                if (int_clear)
                begin
                    alert_q <= trip;
                    rd_seen_q <= 1'b0;
                    below_seen_q <= 1'b0;
                end
            end
        end
    end

    // open-drain alert; pull low when the pin's level should be low
    assign alert_output_o = 1'b0;
    assign alert_output_oe_o = alert_q ^ config_q[CFG_POLARITY];
    assign adc_power_o = (cv_state_q != CV_IDLE);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_result_only_on_load;
        !$stable(temp_result_q) |-> $past(load_en);
    endproperty
    a_result_only_on_load: assert property (p_result_only_on_load) else $error("result changed without conversion");

    property p_load_value;
        load_en |=> temp_result_q[3:0] == 4'h0 && temp_result_q[15:4] == $past(temp_sample_i);
    endproperty
    a_load_value: assert property (p_load_value) else $error("stored result wrong");

    property p_shutdown_stays;
        (ce_i && cv_state_q == CV_IDLE && cfg_off && !oneshot_hit) |=> cv_state_q == CV_IDLE;
    endproperty
    a_shutdown_stays: assert property (p_shutdown_stays) else $error("converted while shut down");

    property p_oneshot_returns;
        (cv_state_q == CV_ONESHOT && load_en) |=> cv_state_q == CV_IDLE && !adc_power_o;
    endproperty
    a_oneshot_returns: assert property (p_oneshot_returns) else $error("one-shot did not power down");

    property p_oneshot_not_stored;
        oneshot_hit |=> $stable(config_q) && $stable(hyst_q) && $stable(overtemp_q);
    endproperty
    a_oneshot_not_stored: assert property (p_oneshot_not_stored) else $error("one-shot data stored");

    property p_cmp_clear;
        (!int_mode && load_en && is_below && !trip) |=> !alert_q;
    endproperty
    a_cmp_clear: assert property (p_cmp_clear) else $error("comparator output did not clear");

    property p_int_hold;
        (int_mode && alert_q && !rd_seen_q && ce_i) ##1 int_mode |-> alert_q;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt output cleared without read");

    property p_fault_reset;
        (load_en && !is_fault) |=> fault_cnt_q == 3'h0;
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("fault counter not reset");

    property p_pointer_load;
        ptr_write |=> pointer_q == $past(ev_q.data) ##1 pointer_q == $past(pointer_q);
    endproperty
    a_pointer_load: assert property (p_pointer_load) else $error("pointer not loaded");

    property p_polarity_low;
        (alert_q && !config_q[CFG_POLARITY]) |-> alert_output_oe_o;
    endproperty
    a_polarity_low: assert property (p_polarity_low) else $error("active-low alert not driven");

    c_trip: cover property (trip ##1 alert_q);
    c_oneshot: cover property (oneshot_hit ##1 cv_state_q == CV_ONESHOT);
    c_int_clear: cover property (int_mode && int_clear);
    c_limit_write: cover property (lim_commit);

endmodule // tsc_temp_sensor

// ---- testbench/tsc_bus_master.sv ----
`timescale 1ns/1ns
// bus master model: open drain, it only ever pulls the data line low
module tsc_bus_master
(
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // idle bus: clock high, data released
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // data moves only while the clock is low, so no false start or stop
    task automatic bit_x(input logic b, output logic r);
        sda_low_o = !b;
        #150 scl_o = 1'b1;
        #200 r = sda_i;
        scl_o = 1'b0;
        #50;
    endtask
    task automatic start();
        sda_low_o = 1'b0;
        #100 scl_o = 1'b1;
        #200 sda_low_o = 1'b1;
        #200 scl_o = 1'b0;
        #50; // data must not move in the same step as the clock falls
    endtask
    task automatic stop();
        sda_low_o = 1'b1;
        #100 scl_o = 1'b1;
        #200 sda_low_o = 1'b0;
        #200;
    endtask
    // eight bits msb first, then the ninth (acknowledge) bit
    task automatic xfer(input logic [7:0] w, input logic nine, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(w[i], r[i]);
        end
        bit_x(nine, a);
    endtask
endmodule // tsc_bus_master

// ---- testbench/tsc_temp_sensor_tb_top.sv ----
`timescale 1ns/1ns
module tsc_temp_sensor_tb_top;
    import tsc_pkg::*;
    localparam int UPD = 200;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] sample = 12'h190;
    logic scl, m_low, dut_oe, sda, alert_oe, power;
    logic [15:0] v;
    logic [7:0] r8;
    logic ack;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    // wired-and with pull-up: anyone driving low wins
    assign sda = !(m_low || dut_oe);
    always #5 clk = !clk;
    // link clock starts in phase with the core clock: first rising edges of both fall at 5 ns
    initial
    begin
        #2;
        forever #3 lclk = !lclk;
    end
    tsc_temp_sensor #(.UPDATE_CYCLES(UPD), .ONESHOT_CYCLES(100), .TIMEOUT_CYCLES(2000)) tsc_temp_sensor_i (
        .core_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .link_clk_i(lclk), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(dut_oe), .address_select_pin_i(1'b1), .temp_sample_i(sample),
        .adc_power_o(power), .alert_output_o(), .alert_output_oe_o(alert_oe));
    tsc_bus_master tsc_bus_master_i (.sda_i(sda), .scl_o(scl), .sda_low_o(m_low));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // a hung handshake cannot stall the run forever
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            failures++;
            report_and_stop();
        end
    end
    task automatic wr(input logic [2:0] p, input logic [15:0] d, input int n);
        logic [7:0] r;
        logic a;
        tsc_bus_master_i.start();
        tsc_bus_master_i.xfer({ADDR_FIXED, 3'h2, 1'b0}, 1'b1, r, a);
        check({15'h0000, a}, 16'h0000);
        tsc_bus_master_i.xfer({5'h00, p}, 1'b1, r, a);
        if (n > 0)
            tsc_bus_master_i.xfer(d[15:8], 1'b1, r, a);
        if (n > 1)
            tsc_bus_master_i.xfer(d[7:0], 1'b1, r, a);
        tsc_bus_master_i.stop();
    endtask
    // read at the current pointer, upper byte first, master ends with a nack
    task automatic rd_cur(input int n, output logic [15:0] d);
        logic [7:0] r;
        logic a;
        d = 16'h0000;
        tsc_bus_master_i.start();
        tsc_bus_master_i.xfer({ADDR_FIXED, 3'h2, 1'b1}, 1'b1, r, a);
        tsc_bus_master_i.xfer(8'hff, n == 1, d[15:8], a);
        if (n == 2)
            tsc_bus_master_i.xfer(8'hff, 1'b1, d[7:0], a);
        tsc_bus_master_i.stop();
    endtask
    task automatic rd(input logic [2:0] p, input int n, input logic [15:0] exp);
        logic [15:0] d;
        wr(p, 16'h0000, 0);
        rd_cur(n, d);
        check(d, exp);
    endtask
    // reserved bit 6 is always sent as zero
    task automatic cfg(input logic [7:0] c);
        wr(PTR_CONFIG, {c & 8'hbf, 8'h00}, 1);
    endtask
    task automatic conv(input int n);
        repeat (n * UPD) @(posedge clk);
        #1;
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        conv(3);
        rd_cur(2, v);
        check(v, 16'h1900);
        rd(PTR_CONFIG, 1, 16'h0000);
        rd(PTR_HYST, 2, 16'h4b00);
        rd(PTR_OVERTEMP, 2, 16'h5000);
        $display("test 1 done");
        wr(PTR_RESULT, 16'haaaa, 2);
        rd(PTR_RESULT, 2, 16'h1900);
        wr(PTR_HYST, 16'h4a5f, 2);
        rd(PTR_HYST, 2, 16'h4a50);
        wr(PTR_OVERTEMP, 16'h5100, 1);
        rd(PTR_OVERTEMP, 2, 16'h5000);
        $display("test 2 done");
        check({15'h0000, alert_oe}, 16'h0000);
        sample = 12'h500;
        conv(3);
        check({15'h0000, alert_oe}, 16'h0001);
        sample = 12'h4a5;
        conv(3);
        check({15'h0000, alert_oe}, 16'h0001);
        sample = 12'h400;
        conv(3);
        check({15'h0000, alert_oe}, 16'h0000);
        cfg(8'h04);
        check({15'h0000, alert_oe}, 16'h0001);
        $display("test 3 done");
        cfg(8'h02);
        sample = 12'h500;
        conv(3);
        check({15'h0000, alert_oe}, 16'h0001);
        sample = 12'h400;
        conv(3);
        check({15'h0000, alert_oe}, 16'h0001);
        rd(PTR_CONFIG, 1, 16'h0200);
        conv(3);
        check({15'h0000, alert_oe}, 16'h0000);
        $display("test 4 done");
        cfg(8'h18);
        sample = 12'h500;
        conv(4);
        check({15'h0000, alert_oe}, 16'h0000);
        conv(4);
        check({15'h0000, alert_oe}, 16'h0001);
        cfg(8'h01);
        sample = 12'h321;
        conv(3);
        check({15'h0000, power}, 16'h0000);
        rd(PTR_RESULT, 2, 16'h5000);
        wr(PTR_ONESHOT, 16'h0000, 1);
        conv(2);
        rd(PTR_RESULT, 2, 16'h3210);
        check({15'h0000, power}, 16'h0000);
        cfg(8'h20);
        sample = 12'h7d0;
        conv(3);
        rd(PTR_RESULT, 2, 16'h3210);
        wr(PTR_ONESHOT, 16'hff00, 1);
        conv(2);
        rd(PTR_RESULT, 2, 16'h7d00);
        rd(PTR_CONFIG, 1, 16'h2000);
        $display("test 5 done");
        // stall a read while the device pulls the data line low; the silence timer must free it
        tsc_bus_master_i.start();
        tsc_bus_master_i.xfer({ADDR_FIXED, 3'h2, 1'b1}, 1'b1, r8, ack);
        check({15'h0000, dut_oe}, 16'h0001);
        repeat (2100) @(posedge clk);
        #1;
        check({15'h0000, dut_oe}, 16'h0000);
        tsc_bus_master_i.stop();
        $display("test 6 done");
        // bus alert role behaves as interrupt: no self clearing until a read
        sample = 12'h400;
        cfg(8'h80);
        conv(3);
        check({15'h0000, alert_oe}, 16'h0001);
        rd(PTR_RESULT, 2, 16'h4000);
        check({15'h0000, alert_oe}, 16'h0000);
        $display("test 7 done");
        report_and_stop();
    end
endmodule // tsc_temp_sensor_tb_top
